// File: rtl/drt_pkg.sv
/*
 * Constants for the dual reload down timer: register addresses, field
 * positions, reset values and divider counts.
 * Assumes a nibble-wide register port driven by a 4-bit CPU core.
 */
package drt_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 4;
    localparam int CNT_W = 8;
    localparam int NUM_CH = 2;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [ADDR_W-1:0] ADDR_MODE = 16'hFFC0;
    localparam logic [ADDR_W-1:0] ADDR_OUT_SRC = 16'hFFC1;
    localparam logic [NUM_CH-1:0][ADDR_W-1:0] ADDR_CH_CTRL = {16'hFFC3, 16'hFFC2};
    localparam logic [NUM_CH-1:0][ADDR_W-1:0] ADDR_RELOAD_LO = {16'hFFC6, 16'hFFC4};
    localparam logic [NUM_CH-1:0][ADDR_W-1:0] ADDR_RELOAD_HI = {16'hFFC7, 16'hFFC5};
    localparam logic [NUM_CH-1:0][ADDR_W-1:0] ADDR_COUNT_LO = {16'hFFCA, 16'hFFC8};
    localparam logic [NUM_CH-1:0][ADDR_W-1:0] ADDR_COUNT_HI = {16'hFFCB, 16'hFFC9};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 16'hFFE2;
    localparam logic [ADDR_W-1:0] ADDR_FLAG = 16'hFFF2;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_EDGE_POL = 0;
    localparam int BIT_NOISE_REJ = 1;
    localparam int BIT_EVENT_MODE = 2;
    localparam int BIT_SRC_SEL0 = 0;
    localparam int BIT_OUT_EN = 2;
    localparam int BIT_OUT_CH_SEL = 3;
    localparam int BIT_RUN = 0;
    localparam int BIT_PRESET = 1;
    localparam int BIT_DIV_LO = 2;
    localparam int BIT_DIV_HI = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [CNT_W-1:0] RST_COUNT = 8'h00;
    localparam logic [CNT_W-1:0] RST_RELOAD = 8'h00;
    localparam logic [DATA_W-1:0] RST_NIBBLE = 4'h0;

    // ************************************************************
    // Divider codes and terminal counts (divisor minus one)
    // ************************************************************
    localparam logic [1:0] DIV_BY_1 = 2'h0;
    localparam logic [1:0] DIV_BY_4 = 2'h1;
    localparam logic [1:0] DIV_BY_32 = 2'h2;
    localparam logic [CNT_W-1:0] TERM_DIV_4 = 8'h03;
    localparam logic [CNT_W-1:0] TERM_DIV_32 = 8'h1F;
    localparam logic [CNT_W-1:0] TERM_DIV_256 = 8'hFF;

    // ************************************************************
    // Noise rejector timing
    // ************************************************************
    localparam int LF_OSC_HZ = 32768;
    localparam int NR_CLK_HZ = 2048;
    localparam logic [3:0] NR_DIV_TERM = 4'(LF_OSC_HZ / NR_CLK_HZ - 1);
    localparam logic [1:0] NR_PASS_EDGES = 2'h2;

endpackage

// File: rtl/drt_prescaler.sv
/*
 * Per-channel prescaler: divides one-cycle source ticks by 1, 4, 32 or 256.
 * Assumes srcTick is a single-cycle pulse on sys_clk.
 */
module drt_prescaler
    import drt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Control
    input wire logic run,
    input wire logic [1:0] divSel,
    input wire logic srcTick,
    // Divided tick
    output logic divTick
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic tick;
    } drt_psc_s;

    drt_psc_s state;
    drt_psc_s next_state;
    logic [CNT_W-1:0] term;

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        case (divSel)
            DIV_BY_1: term = RST_COUNT;
            DIV_BY_4: term = TERM_DIV_4;
            DIV_BY_32: term = TERM_DIV_32;
            default: term = TERM_DIV_256;
        endcase
        if (!run) begin
            next_state.count = RST_COUNT;
        end else if (srcTick) begin
            if (state.count >= term) begin
                next_state.count = RST_COUNT;
                next_state.tick = 1'b1;
            end else begin
                next_state.count = state.count + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign divTick = state.tick;
endmodule

// File: rtl/drt_noise_filter.sv
/*
 * Chatter filter for the synchronised event level.
 * Assumes slowTick marks each falling edge of the 2,048 Hz reference.
 */
module drt_noise_filter
    import drt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Filter input
    input wire logic enable,
    input wire logic slowTick,
    input wire logic levelIn,
    // Filtered level
    output logic levelOut
);
    typedef struct packed {
        logic level;
        logic [1:0] edges;
    } drt_nf_s;

    drt_nf_s state;
    drt_nf_s next_state;

    always_comb begin
        next_state = state;
        if (!enable || levelIn == state.level) begin
            next_state.level = levelIn;
            next_state.edges = 2'h0;
        end else if (slowTick) begin
            // A change must survive two reference edges before it counts
            if (state.edges + 2'h1 >= NR_PASS_EDGES) begin
                next_state.level = levelIn;
                next_state.edges = 2'h0;
            end else begin
                next_state.edges = state.edges + 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign levelOut = state.level;
endmodule

// File: rtl/drt_top.sv
/*
 * Dual reload down timer: two 8-bit reloading down-counters with
 * prescalers, an event-counting mode on channel 0, underflow flags,
 * a toggled pulse output and a serial bit clock.
 * Assumes both oscillators and the event pin are asynchronous to sys_clk
 * and toggle well below half its rate; the register port is nibble wide.
 */
// Added by the designer: the address-and-strobe port and the register addresses.
module drt_top
    import drt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    // Oscillators and event pin
    input wire logic lowFreqOsc,
    input wire logic highFreqOsc,
    input wire logic eventInputPin,
    // Outputs
    output logic togglePulseOut,
    output logic serialBitClk,
    output logic ch0IrqReq,
    output logic ch1IrqReq
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic lfSync1;
        logic lfSync2;
        logic lfPrev;
        logic hfSync1;
        logic hfSync2;
        logic hfPrev;
        logic evSync1;
        logic evSync2;
        logic evPrev;
        logic lfTick;
        logic hfTick;
        logic [3:0] nrDiv;
        logic nrTick;
        logic ch0EventMode;
        logic noiseRejectEnable;
        logic eventEdgePolarity;
        logic pulseOutChannelSel;
        logic pulseOutEnable;
        logic [NUM_CH-1:0] srcSel;
        logic [NUM_CH-1:0][1:0] divSel;
        logic [NUM_CH-1:0] run;
        logic [NUM_CH-1:0][CNT_W-1:0] reload;
        logic [NUM_CH-1:0][CNT_W-1:0] count;
        logic [NUM_CH-1:0][DATA_W-1:0] heldHigh;
        logic [NUM_CH-1:0] heldValid;
        logic [NUM_CH-1:0] underflowFlag;
        logic [NUM_CH-1:0] irqEnable;
        logic toggleLevel;
        logic serialLevel;
        logic togglePulseOut;
        logic serialBitClk;
        logic [NUM_CH-1:0] irqReq;
        logic [DATA_W-1:0] rdData;
    } drt_top_s;

    drt_top_s state;
    drt_top_s next_state;

    logic [NUM_CH-1:0] pscTick;
    logic [NUM_CH-1:0] pscRun;
    logic [NUM_CH-1:0] countTick;
    logic [NUM_CH-1:0] underflow;
    logic evFiltered;
    logic eventEdge;
    logic selUnderflow;

    // ************************************************************
    // Prescalers, one per channel
    // ************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : gen_psc
            drt_prescaler u_psc (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                // Event mode leaves channel 0's divider idle
                .run(pscRun[ch]),
                .divSel(state.divSel[ch]),
                .srcTick(state.srcSel[ch] ? state.hfTick : state.lfTick),
                .divTick(pscTick[ch])
            );
        end
    endgenerate

    assign pscRun[0] = state.run[0] && !state.ch0EventMode;
    assign pscRun[1] = state.run[1];

    // ************************************************************
    // Event pin filter
    // ************************************************************
    drt_noise_filter u_nf (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .enable(state.noiseRejectEnable),
        .slowTick(state.nrTick),
        .levelIn(state.evSync2),
        .levelOut(evFiltered)
    );

    // ************************************************************
    // Count clocks and underflow
    // ************************************************************
    always_comb begin
        // Polarity 0 counts high-to-low, 1 counts low-to-high
        if (state.eventEdgePolarity) begin
            eventEdge = evFiltered && !state.evPrev;
        end else begin
            eventEdge = !evFiltered && state.evPrev;
        end
        // Channel 0 picks its count source by mode; channel 1 never counts events
        countTick[0] = state.ch0EventMode ? (state.run[0] && eventEdge)
                                          : pscTick[0];
        countTick[1] = pscTick[1];
        for (int i = 0; i < NUM_CH; i++) begin
            // Gate the count clock with the run bit only
            countTick[i] = countTick[i] && state.run[i];
            underflow[i] = countTick[i] && (state.count[i] == RST_COUNT);
        end
        selUnderflow = state.pulseOutChannelSel ? underflow[1] : underflow[0];
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        next_state = state;

        // Two flops on every asynchronous input before use
        next_state.lfSync1 = lowFreqOsc;
        next_state.lfSync2 = state.lfSync1;
        next_state.lfPrev = state.lfSync2;
        next_state.hfSync1 = highFreqOsc;
        next_state.hfSync2 = state.hfSync1;
        next_state.hfPrev = state.hfSync2;
        next_state.evSync1 = eventInputPin;
        next_state.evSync2 = state.evSync1;
        next_state.evPrev = evFiltered;
        next_state.lfTick = state.lfSync2 && !state.lfPrev;
        next_state.hfTick = state.hfSync2 && !state.hfPrev;

        // 2,048 Hz reference from the low-frequency oscillator
        next_state.nrTick = 1'b0;
        if (state.lfTick) begin
            if (state.nrDiv == NR_DIV_TERM) begin
                next_state.nrDiv = 4'h0;
                next_state.nrTick = 1'b1;
            end else begin
                next_state.nrDiv = state.nrDiv + 4'h1;
            end
        end

        // Counters
        for (int i = 0; i < NUM_CH; i++) begin
            if (underflow[i]) begin
                next_state.count[i] = state.reload[i];
            end else if (countTick[i]) begin
                next_state.count[i] = state.count[i] - 8'h01;
            end
        end

        // Register writes
        if (regWr) begin
            if (regAddr == ADDR_MODE) begin
                next_state.ch0EventMode = regWrData[BIT_EVENT_MODE];
                next_state.noiseRejectEnable = regWrData[BIT_NOISE_REJ];
                next_state.eventEdgePolarity = regWrData[BIT_EDGE_POL];
            end
            if (regAddr == ADDR_OUT_SRC) begin
                next_state.pulseOutChannelSel = regWrData[BIT_OUT_CH_SEL];
                next_state.pulseOutEnable = regWrData[BIT_OUT_EN];
                next_state.srcSel = regWrData[BIT_SRC_SEL0 +: NUM_CH];
            end
            if (regAddr == ADDR_IRQ_EN) begin
                next_state.irqEnable = regWrData[NUM_CH-1:0];
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (regAddr == ADDR_CH_CTRL[i]) begin
                    next_state.divSel[i] = regWrData[BIT_DIV_HI:BIT_DIV_LO];
                    next_state.run[i] = regWrData[BIT_RUN];
                    // Preset beats a same-cycle count or reload
                    if (regWrData[BIT_PRESET]) begin
                        next_state.count[i] = state.reload[i];
                    end
                end
                if (regAddr == ADDR_RELOAD_LO[i]) begin
                    next_state.reload[i][3:0] = regWrData;
                end
                if (regAddr == ADDR_RELOAD_HI[i]) begin
                    next_state.reload[i][7:4] = regWrData;
                end
            end
        end

        // Underflow flags: a new underflow wins over a same-cycle clear
        for (int i = 0; i < NUM_CH; i++) begin
            if (regWr && regAddr == ADDR_FLAG && regWrData[i]) begin
                next_state.underflowFlag[i] = 1'b0;
            end
            if (underflow[i]) begin
                next_state.underflowFlag[i] = 1'b1;
            end
            next_state.irqReq[i] = next_state.underflowFlag[i] && state.irqEnable[i];
        end

        // Pulse output and serial clock run at half the underflow rate
        if (selUnderflow) begin
            next_state.toggleLevel = !state.toggleLevel;
        end
        if (underflow[1]) begin
            next_state.serialLevel = !state.serialLevel;
        end
        // Output idles high while disabled
        next_state.togglePulseOut = !next_state.pulseOutEnable || next_state.toggleLevel;
        next_state.serialBitClk = next_state.serialLevel;

        // Register reads: data stands only in the cycle after the strobe
        next_state.rdData = RST_NIBBLE;
        if (regRd) begin
            case (regAddr)
                ADDR_MODE: begin
                    next_state.rdData = {1'b0, state.ch0EventMode,
                                         state.noiseRejectEnable, state.eventEdgePolarity};
                end
                ADDR_OUT_SRC: begin
                    next_state.rdData = {state.pulseOutChannelSel, state.pulseOutEnable,
                                         state.srcSel};
                end
                ADDR_IRQ_EN: begin
                    next_state.rdData = {2'b00, state.irqEnable};
                end
                ADDR_FLAG: begin
                    next_state.rdData = {2'b00, state.underflowFlag};
                end
                default: begin
                    next_state.rdData = RST_NIBBLE;
                end
            endcase
            for (int i = 0; i < NUM_CH; i++) begin
                if (regAddr == ADDR_CH_CTRL[i]) begin
                    // Preset strobe always reads back as zero
                    next_state.rdData = {state.divSel[i], 1'b0, state.run[i]};
                end
                if (regAddr == ADDR_RELOAD_LO[i]) begin
                    next_state.rdData = state.reload[i][3:0];
                end
                if (regAddr == ADDR_RELOAD_HI[i]) begin
                    next_state.rdData = state.reload[i][7:4];
                end
                if (regAddr == ADDR_COUNT_LO[i]) begin
                    next_state.rdData = state.count[i][3:0];
                    // Freeze the upper half so a borrow cannot tear the pair
                    next_state.heldHigh[i] = state.count[i][7:4];
                    next_state.heldValid[i] = 1'b1;
                end
                if (regAddr == ADDR_COUNT_HI[i]) begin
                    next_state.rdData = state.heldValid[i] ? state.heldHigh[i]
                                                           : state.count[i][7:4];
                    next_state.heldValid[i] = 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
            state.togglePulseOut <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign regRdData = state.rdData;
    assign togglePulseOut = state.togglePulseOut;
    assign serialBitClk = state.serialBitClk;
    assign ch0IrqReq = state.irqReq[0];
    assign ch1IrqReq = state.irqReq[1];
endmodule

// File: tb/drt_top_chk.sv
/*
 * Port checker for the dual reload down timer.
 * Assumes a bind to drt_top and oscillators far slower than sys_clk.
 */
module drt_top_chk
    import drt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [DATA_W-1:0] regRdData,
    // Pins
    input wire logic lowFreqOsc,
    input wire logic highFreqOsc,
    input wire logic eventInputPin,
    input wire logic togglePulseOut,
    input wire logic serialBitClk,
    input wire logic ch0IrqReq,
    input wire logic ch1IrqReq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // ****
    // Port relations
    // ****
    chk_rd_idle_zero: assert property (
        !$past(regRd) |-> regRdData == 4'h0)
        else $error("read data outside a read answer");
    chk_preset_zero: assert property (
        regRd && (regAddr == ADDR_CH_CTRL[0] || regAddr == ADDR_CH_CTRL[1])
        |=> !regRdData[BIT_PRESET]) else $error("preset strobe read back");
    chk_mode_top_zero: assert property (
        regRd && regAddr == ADDR_MODE |=> !regRdData[3])
        else $error("unused mode bit read as one");
    chk_flag_top_zero: assert property (
        regRd && (regAddr == ADDR_IRQ_EN || regAddr == ADDR_FLAG) |=> regRdData[3:2] == 2'h0)
        else $error("unused flag bits read as one");
    chk_irq0_masked: assert property (
        regWr && regAddr == ADDR_IRQ_EN && !regWrData[0] ##1 !regWr |=> !ch0IrqReq)
        else $error("channel 0 request while masked");
    chk_irq1_masked: assert property (
        regWr && regAddr == ADDR_IRQ_EN && !regWrData[1] ##1 !regWr |=> !ch1IrqReq)
        else $error("channel 1 request while masked");
    chk_toggle_pulse_out_off_high: assert property (
        regWr && regAddr == ADDR_OUT_SRC && !regWrData[BIT_OUT_EN] ##1 !regWr
        |=> togglePulseOut) else $error("pulse output not high when off");
    chk_serial_steady: assert property (
        $changed(serialBitClk) |=> $stable(serialBitClk))
        else $error("serial clock toggled twice in a row");
endmodule

// File: tb/drt_event_source.sv
/*
 * Model of the external pulse source on the event pin.
 * Assumes a pulled-up pin idling high and a 100 ns sys_clk.
 */
module drt_event_source (
    // Clock
    input wire logic sys_clk,
    // Event pin
    output logic eventInputPin
);
    timeunit 1ns;
    timeprecision 1ns;
    // 0.98 msec of 100 ns cycles; filtered levels get a margin on top
    localparam int MIN_HOLD = 9800;
    initial eventInputPin = 1'b1;
    task automatic drive(input logic lvl, input logic filtered);
        @(posedge sys_clk);
        eventInputPin <= lvl;
        repeat (filtered ? MIN_HOLD + 200 : 30) @(posedge sys_clk);
    endtask
    // Chatter far shorter than the filter window, on purpose
    task automatic spike();
        @(posedge sys_clk);
        eventInputPin <= ~eventInputPin;
        repeat (50) @(posedge sys_clk);
        eventInputPin <= ~eventInputPin;
        repeat (50) @(posedge sys_clk);
    endtask
endmodule

// File: tb/test_dual_reload_down_timer.sv
/*
 * Self-checking bench for the dual reload down timer.
 * Assumes drt_top, its checker and the event source model.
 */
module test_dual_reload_down_timer
    import drt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic lowFreqOsc = 1'b0;
    logic highFreqOsc = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic eventInputPin, togglePulseOut, serialBitClk, ch0IrqReq, ch1IrqReq;
    logic lfFree = 1'b0;
    logic rdPrev = 1'b0;
    logic [DATA_W-1:0] expQ[$];
    logic [7:0] r;
    logic t0;
    int mismatches = 0;
    int checks_done = 0;
    always #50 sys_clk = ~sys_clk;
    drt_top dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .lowFreqOsc(lowFreqOsc),
        .highFreqOsc(highFreqOsc), .eventInputPin(eventInputPin),
        .togglePulseOut(togglePulseOut), .serialBitClk(serialBitClk),
        .ch0IrqReq(ch0IrqReq), .ch1IrqReq(ch1IrqReq));
    drt_event_source src (.sys_clk(sys_clk), .eventInputPin(eventInputPin));
    // ****
    // Shared tasks
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One-cycle strobe; a read notes its expected nibble first
    task automatic access(input logic [15:0] a, input logic [3:0] d, input logic rd);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= !rd;
        regRd <= rd;
        if (rd) begin
            expQ.push_back(d);
        end
        @(posedge sys_clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
    endtask
    task automatic rd8(input int ch, input logic [7:0] v);
        access(ADDR_COUNT_LO[ch], v[3:0], 1'b1);
        access(ADDR_COUNT_HI[ch], v[7:4], 1'b1);
    endtask
    task automatic osc(input logic hf, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            {highFreqOsc, lowFreqOsc} <= {hf, !hf};
            repeat (3) @(posedge sys_clk);
            {highFreqOsc, lowFreqOsc} <= 2'h0;
            repeat (3) @(posedge sys_clk);
        end
        repeat (8) @(posedge sys_clk);
    endtask
    always @(negedge sys_clk) begin
        if (rdPrev) begin
            check(regRdData, expQ.pop_front());
        end
        rdPrev = regRd;
    end
    always begin
        repeat (150) @(posedge sys_clk);
        if (lfFree) begin
            lowFreqOsc <= ~lowFreqOsc;
        end
    end
    // About 50k cycles are expected; double that means a hang
    initial begin
        #10_000_000;
        mismatches++;
        close_out();
    end
    // ****
    // Main sequence
    // ****
    initial begin
        void'($urandom(32'hCDC2));
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int a = 16'hFFC0; a <= 16'hFFCC; a++) begin
            access(16'(a), 4'h0, 1'b1);
        end
        access(ADDR_FLAG, 4'h0, 1'b1);
        access(16'hFFCC, 4'hF, 1'b0);
        access(16'hFFCC, 4'h0, 1'b1);
        @(negedge sys_clk);
        check({togglePulseOut, serialBitClk, ch1IrqReq, ch0IrqReq}, 8'h08);
        r = 8'($urandom_range(255, 4));
        access(ADDR_RELOAD_LO[0], r[3:0], 1'b0);
        access(ADDR_RELOAD_HI[0], r[7:4], 1'b0);
        access(ADDR_OUT_SRC, 4'h1, 1'b0);
        for (int c = 0; c < 4; c++) begin
            access(ADDR_CH_CTRL[0], {2'(c), 2'h3}, 1'b0);
            osc(1'b0, 3);
            osc(1'b1, 2 << (c == 0 ? 0 : c == 1 ? 2 : c == 2 ? 5 : 8));
            access(ADDR_CH_CTRL[0], {2'(c), 2'h0}, 1'b0);
            osc(1'b1, 2);
            access(ADDR_CH_CTRL[0], {2'(c), 2'h0}, 1'b1);
            rd8(0, r - 8'h02);
        end
        access(ADDR_CH_CTRL[0], 4'h1, 1'b0);
        osc(1'b1, 1);
        access(ADDR_CH_CTRL[0], 4'h0, 1'b0);
        rd8(0, r - 8'h03);
        access(ADDR_RELOAD_LO[0], 4'h0, 1'b0);
        access(ADDR_RELOAD_HI[0], 4'h3, 1'b0);
        access(ADDR_CH_CTRL[0], 4'h3, 1'b0);
        access(ADDR_COUNT_LO[0], 4'h0, 1'b1);
        osc(1'b1, 1);
        access(ADDR_COUNT_HI[0], 4'h3, 1'b1);
        access(ADDR_CH_CTRL[0], 4'h0, 1'b0);
        rd8(0, 8'h2F);
        access(ADDR_RELOAD_LO[1], 4'h1, 1'b0);
        access(ADDR_OUT_SRC, 4'hC, 1'b0);
        @(negedge sys_clk);
        t0 = togglePulseOut;
        access(ADDR_CH_CTRL[1], 4'h3, 1'b0);
        osc(1'b0, 2);
        access(ADDR_CH_CTRL[1], 4'h0, 1'b0);
        rd8(1, 8'h01);
        access(ADDR_FLAG, 4'h2, 1'b1);
        @(negedge sys_clk);
        check({ch1IrqReq, serialBitClk, togglePulseOut}, {2'h1, ~t0});
        access(ADDR_IRQ_EN, 4'h2, 1'b0);
        repeat (2) @(negedge sys_clk);
        check(ch1IrqReq, 1'b1);
        access(ADDR_IRQ_EN, 4'h0, 1'b0);
        access(ADDR_FLAG, 4'h2, 1'b1);
        @(negedge sys_clk);
        check(ch1IrqReq, 1'b0);
        access(ADDR_FLAG, 4'h2, 1'b0);
        access(ADDR_FLAG, 4'h0, 1'b1);
        access(ADDR_RELOAD_LO[0], 4'h0, 1'b0);
        access(ADDR_RELOAD_HI[0], 4'h1, 1'b0);
        lfFree <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            access(ADDR_MODE, {2'h1, 2'(m)}, 1'b0);
            access(ADDR_MODE, {2'h1, 2'(m)}, 1'b1);
            access(ADDR_CH_CTRL[0], 4'hF, 1'b0);
            if (m > 1) begin
                src.spike();
            end
            src.drive(1'b0, m > 1);
            rd8(0, m[0] ? 8'h10 : 8'h0F);
            src.drive(1'b1, m > 1);
            rd8(0, 8'h0F);
        end
        lfFree <= 1'b0;
        @(negedge sys_clk);
        check(serialBitClk, 1'b1);
        repeat (2) @(posedge sys_clk);
        close_out();
    end
endmodule

bind drt_top drt_top_chk chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .lowFreqOsc(lowFreqOsc),
    .highFreqOsc(highFreqOsc), .eventInputPin(eventInputPin),
    .togglePulseOut(togglePulseOut), .serialBitClk(serialBitClk),
    .ch0IrqReq(ch0IrqReq), .ch1IrqReq(ch1IrqReq));
